// *** dsu_pkg.sv ***
/*
 * dsu_pkg: shared types and constants of the doubleword store unit.
 * assumes a 64-bit core with byte-addressed memory and a 64-bit write path.
 */
package dsu_pkg;

    localparam int unsigned DSU_XLEN       = 64;
    localparam int unsigned DSU_OFS_W      = 16;
    localparam int unsigned DSU_OFS_R6_W   = 11;
    localparam int unsigned DSU_LANES      = 8;
    localparam int unsigned DSU_LOW_BITS   = 3;
    localparam int unsigned DSU_WORD_BIT   = 2;
    localparam logic [2:0]  DSU_ALIGNED    = 3'h0;
    localparam logic [7:0]  DSU_BE_ALL     = 8'hff;
    localparam logic [7:0]  DSU_BE_LO_WORD = 8'h0f;
    localparam logic [7:0]  DSU_BE_HI_WORD = 8'hf0;
    localparam logic [63:0] DSU_WORD_FLIP  = 64'h4;
    localparam logic [63:0] DSU_DW_STEP    = 64'h8;
    localparam logic [63:0] DSU_DW_MASK    = 64'hffff_ffff_ffff_fff8;

    typedef enum logic [2:0] {
        DSU_OP_INT   = 3'h0,
        DSU_OP_FLT   = 3'h1,
        DSU_OP_COP2  = 3'h2,
        DSU_OP_LEFT  = 3'h3,
        DSU_OP_RIGHT = 3'h4
    } dsu_op_t;

    typedef enum logic [1:0] {
        DSU_K_FULL  = 2'h0,
        DSU_K_LEFT  = 2'h1,
        DSU_K_RIGHT = 2'h2
    } dsu_kind_t;

    typedef enum logic [3:0] {
        DSU_EXC_NONE     = 4'h0,
        DSU_EXC_ADDR     = 4'h1,
        DSU_EXC_RESERVED = 4'h2,
        DSU_EXC_COP_UNUS = 4'h3,
        DSU_EXC_REFILL   = 4'h4,
        DSU_EXC_INVALID  = 4'h5,
        DSU_EXC_MODIFIED = 4'h6,
        DSU_EXC_WATCH    = 4'h7,
        DSU_EXC_BUS      = 4'h8
    } dsu_exc_t;

    typedef enum logic [3:0] {
        DSU_ST_IDLE = 4'b0001,
        DSU_ST_XLAT = 4'b0010,
        DSU_ST_WR1  = 4'b0100,
        DSU_ST_WR2  = 4'b1000
    } dsu_state_e_t;

    typedef struct packed {
        dsu_op_t     op;
        logic [63:0] base;
        logic [15:0] offset;
        logic [63:0] int_data;
        logic [63:0] flt_data;
        logic [63:0] cop2_lo;
        logic [63:0] cop2_hi;
    } dsu_issue_t;

    typedef struct packed {
        logic [63:0] paddr;
        logic [2:0]  cca;
        logic        refill;
        logic        invalid;
        logic        modified;
        logic        watch;
    } dsu_xlat_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] addr;
        logic [7:0]  be;
        logic [63:0] data;
        logic [2:0]  cca;
    } dsu_mem_req_t;

endpackage : dsu_pkg

// *** dsu_store_unit.sv ***
/*
 * dsu_store_unit: doubleword store path (integer, float, cop2, left/right).
 * assumes one store issued at a time while o_ready is high, a translation
 * unit answering o_xlat_req with i_xlat_ack, and memory answering each
 * write request with i_mem_ack (plus i_mem_bus_err on a failed write).
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - address is base plus sign-extended displacement
// - integer store writes full 64-bit register
// - pre-release-six misaligned store traps, no write
// - release six splits misaligned store in hardware
// - translate as data store before any write
// - float store writes 64-bit float register
// - cop2 store writes 64-bit cop2 data
// - aligned cop2 low word first, high word at addr^4
// - cop2 displacement 11-bit in release six
// - store-left writes most significant bytes
// - store-right writes least significant bytes
// - lanes chosen by low address bits, endianness
// - release six rejects left/right partial stores
// - float/cop2 report unusable and reserved
// - partial stores also report bus error
module dsu_store_unit
    import dsu_pkg::*;
(
    // clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_nrst,
    // mode
    input  wire logic          i_release6,
    input  wire logic          i_big_endian,
    input  wire logic          i_cop_usable,
    // issue
    input  wire logic          i_issue_valid,
    input  wire dsu_issue_t    i_issue,
    input  wire logic          i_issue_reserved,
    output logic               o_ready,
    // translation
    output logic               o_xlat_req,
    output logic [63:0]        o_xlat_vaddr,
    input  wire logic          i_xlat_ack,
    input  wire dsu_xlat_rsp_t i_xlat_rsp,
    // memory write
    output dsu_mem_req_t       o_mem_req,
    input  wire logic          i_mem_ack,
    input  wire logic          i_mem_bus_err,
    // completion
    output logic               o_done,
    output logic               o_exc,
    output dsu_exc_t           o_exc_code
);

    typedef struct packed {
        dsu_state_e_t st;
        dsu_op_t      op;
        logic [63:0]  ea;
        logic [63:0]  src;
        logic [63:0]  src_hi;
        logic         big;
        logic         split;
        logic         xlat_req;
        dsu_mem_req_t mem;
        dsu_mem_req_t nxt;
        logic         done;
        logic         exc;
        dsu_exc_t     code;
        logic         ready;
    } dsu_regs_t;

    typedef struct packed {
        logic [7:0]  be;
        logic [63:0] data;
    } dsu_lanes_t;

    // lane i of the write bus is the byte at aligned address + i
    function automatic dsu_lanes_t dsu_map(input dsu_kind_t kind, input logic big,
                                           input logic [2:0] k, input logic [63:0] v);
        dsu_lanes_t r;
        int         src;
        logic       en;
        r = '0;
        for (int l = 0; l < DSU_LANES; l++)
        begin
            en  = 1'b0;
            src = 0;
            case (kind)
                DSU_K_FULL:
                begin
                    en  = 1'b1;
                    src = big ? (7 - l) : l;
                end
                DSU_K_LEFT:
                begin
                    en  = big ? (l >= int'(k)) : (l <= int'(k));
                    src = big ? (7 - l + int'(k)) : (7 - int'(k) + l);
                end
                DSU_K_RIGHT:
                begin
                    en  = big ? (l <= int'(k)) : (l >= int'(k));
                    src = big ? (int'(k) - l) : (l - int'(k));
                end
                default:
                begin
                    en = 1'b0;
                end
            endcase
            if (en)
            begin
                r.be[l]          = 1'b1;
                r.data[8*l +: 8] = v[8*src[2:0] +: 8];
            end
        end
        return r;
    endfunction : dsu_map

    function automatic logic dsu_is_partial(input dsu_op_t op);
        return (op == DSU_OP_LEFT) || (op == DSU_OP_RIGHT);
    endfunction : dsu_is_partial

    dsu_regs_t   q;
    dsu_regs_t   d;
    logic [63:0] ea_w;
    logic [63:0] disp_w;
    logic [63:0] pdw_w;
    dsu_lanes_t  l1_w;
    dsu_lanes_t  l2_w;
    dsu_kind_t   k1_w;
    dsu_kind_t   k2_w;
    logic [2:0]  off_w;
    dsu_lanes_t  l3_w;

    always_comb
    begin
        // cop2 displacement narrows in release six
        if (i_issue.op == DSU_OP_COP2 && i_release6)
            disp_w = {{(DSU_XLEN - DSU_OFS_R6_W){i_issue.offset[DSU_OFS_R6_W - 1]}},
                      i_issue.offset[DSU_OFS_R6_W - 1:0]};
        else
            disp_w = {{(DSU_XLEN - DSU_OFS_W){i_issue.offset[DSU_OFS_W - 1]}},
                      i_issue.offset};
        ea_w  = i_issue.base + disp_w;
        off_w = q.ea[DSU_LOW_BITS - 1:0];
        pdw_w = i_xlat_rsp.paddr & DSU_DW_MASK;
        // misaligned release-six store is two partial writes
        k1_w  = q.big ? DSU_K_LEFT : DSU_K_RIGHT;
        k2_w  = q.big ? DSU_K_RIGHT : DSU_K_LEFT;
        if (q.op == DSU_OP_LEFT)
            k1_w = DSU_K_LEFT;
        else if (q.op == DSU_OP_RIGHT)
            k1_w = DSU_K_RIGHT;
        else if (!q.split)
            k1_w = DSU_K_FULL;
        l1_w = dsu_map(k1_w, q.big, off_w, q.src);
        l2_w = dsu_map(k2_w, q.big, off_w - 3'h1, q.src);
        // cop2 word pair as one doubleword image, each beat enables its half
        l3_w = dsu_map(DSU_K_FULL, q.big, DSU_ALIGNED, {q.src_hi[31:0], q.src[31:0]});
    end

    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        d.exc  = 1'b0;
        d.code = DSU_EXC_NONE;
        case (q.st)
            DSU_ST_IDLE:
            begin
                if (i_issue_valid)
                begin
                    d.op    = i_issue.op;
                    d.ea    = ea_w;
                    d.big   = i_big_endian;
                    d.split = (ea_w[DSU_LOW_BITS - 1:0] != DSU_ALIGNED)
                              && !dsu_is_partial(i_issue.op);
                    d.src_hi = i_issue.cop2_hi;
                    case (i_issue.op)
                        DSU_OP_FLT:  d.src = i_issue.flt_data;
                        DSU_OP_COP2: d.src = i_issue.cop2_lo;
                        default:     d.src = i_issue.int_data;
                    endcase
                    d.exc = 1'b1;
                    if (i_issue_reserved || (i_release6 && dsu_is_partial(i_issue.op)))
                        d.code = DSU_EXC_RESERVED;
                    else if ((i_issue.op == DSU_OP_FLT || i_issue.op == DSU_OP_COP2)
                             && !i_cop_usable)
                        d.code = DSU_EXC_COP_UNUS;
                    else if (!i_release6 && d.split)
                        d.code = DSU_EXC_ADDR;
                    else
                    begin
                        d.exc      = 1'b0;
                        d.st       = DSU_ST_XLAT;
                        d.xlat_req = 1'b1;
                        d.ready    = 1'b0;
                    end
                end
            end
            DSU_ST_XLAT:
            begin
                if (i_xlat_ack)
                begin
                    d.xlat_req = 1'b0;
                    d.exc      = 1'b1;
                    if (i_xlat_rsp.refill)
                        d.code = DSU_EXC_REFILL;
                    else if (i_xlat_rsp.invalid)
                        d.code = DSU_EXC_INVALID;
                    else if (i_xlat_rsp.modified)
                        d.code = DSU_EXC_MODIFIED;
                    else if (i_xlat_rsp.watch)
                        d.code = DSU_EXC_WATCH;
                    else
                        d.exc = 1'b0;
                    if (d.exc)
                    begin
                        d.st    = DSU_ST_IDLE;
                        d.ready = 1'b1;
                    end
                    else
                    begin
                        d.st        = DSU_ST_WR1;
                        d.mem.valid = 1'b1;
                        d.mem.cca   = i_xlat_rsp.cca;
                        d.nxt.cca   = i_xlat_rsp.cca;
                        d.mem.addr  = pdw_w;
                        d.mem.be    = l1_w.be;
                        d.mem.data  = l1_w.data;
                        d.nxt.valid = q.split;
                        d.nxt.addr  = pdw_w + DSU_DW_STEP;
                        d.nxt.be    = l2_w.be;
                        d.nxt.data  = l2_w.data;
                        if (q.op == DSU_OP_COP2 && !q.split)
                        begin
                            // two word writes: low word, then high word at addr^4
                            d.mem.addr  = pdw_w | (q.big ? DSU_WORD_FLIP : '0);
                            d.mem.be    = q.big ? DSU_BE_HI_WORD : DSU_BE_LO_WORD;
                            d.mem.data  = l3_w.data;
                            d.nxt.valid = 1'b1;
                            d.nxt.addr  = d.mem.addr ^ DSU_WORD_FLIP;
                            d.nxt.be    = ~d.mem.be;
                            d.nxt.data  = d.mem.data;
                        end
                    end
                end
            end
            DSU_ST_WR1,
            DSU_ST_WR2:
            begin
                if (i_mem_ack)
                begin
                    if (i_mem_bus_err)
                    begin
                        d.exc       = 1'b1;
                        d.code      = DSU_EXC_BUS;
                        d.mem.valid = 1'b0;
                        d.st        = DSU_ST_IDLE;
                        d.ready     = 1'b1;
                    end
                    else if (q.st == DSU_ST_WR1 && q.nxt.valid)
                    begin
                        d.mem = q.nxt;
                        d.st  = DSU_ST_WR2;
                    end
                    else
                    begin
                        d.mem.valid = 1'b0;
                        d.done      = 1'b1;
                        d.st        = DSU_ST_IDLE;
                        d.ready     = 1'b1;
                    end
                end
            end
            default:
            begin
                d       = '0;
                d.st    = DSU_ST_IDLE;
                d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            q       <= '0;
            q.st    <= DSU_ST_IDLE;
            q.ready <= 1'b1;
        end
        else
            q <= d;
    end

    assign o_ready      = q.ready;
    assign o_xlat_req   = q.xlat_req;
    assign o_xlat_vaddr = q.ea;
    assign o_mem_req    = q.mem;
    assign o_done       = q.done;
    assign o_exc        = q.exc;
    assign o_exc_code   = q.code;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    logic accept_w;
    assign accept_w = i_issue_valid && q.st == DSU_ST_IDLE && !i_issue_reserved;

    chk_misalign_trap: assert property (accept_w && !i_release6
        && !dsu_is_partial(i_issue.op) && ea_w[2:0] != DSU_ALIGNED
        && !((i_issue.op == DSU_OP_FLT || i_issue.op == DSU_OP_COP2) && !i_cop_usable)
        |=> o_exc && o_exc_code == DSU_EXC_ADDR ##1 !o_mem_req.valid)
        else $error("misaligned store did not raise address error");
    chk_r6_no_partial: assert property (accept_w && i_release6
        && dsu_is_partial(i_issue.op) |=> o_exc && o_exc_code == DSU_EXC_RESERVED)
        else $error("partial store accepted in release six");
    chk_cop_unusable: assert property (accept_w && !i_cop_usable
        && i_issue.op == DSU_OP_FLT |=> o_exc && o_exc_code == DSU_EXC_COP_UNUS)
        else $error("float store without coprocessor did not trap");
    chk_xlat_no_write: assert property (q.st == DSU_ST_XLAT && i_xlat_ack
        && (i_xlat_rsp.refill || i_xlat_rsp.modified) |=> o_exc ##0 !o_mem_req.valid [*2])
        else $error("write issued after translation fault");
    chk_write_after_xlat: assert property ($rose(o_mem_req.valid)
        |-> $past(i_xlat_ack) && $past(q.st) == DSU_ST_XLAT)
        else $error("write issued without translation");
    chk_full_lanes: assert property (o_mem_req.valid && q.st == DSU_ST_WR1
        && q.op == DSU_OP_INT && !q.split |-> o_mem_req.be == DSU_BE_ALL)
        else $error("aligned integer store not full width");
    chk_cop2_hi_word: assert property (q.st == DSU_ST_WR1 && q.op == DSU_OP_COP2
        && !q.split && i_mem_ack && !i_mem_bus_err
        |=> o_mem_req.valid && o_mem_req.addr == ($past(o_mem_req.addr) ^ DSU_WORD_FLIP)
            && o_mem_req.be == ~$past(o_mem_req.be))
        else $error("cop2 high word not at flipped word address");
    chk_left_lanes: assert property (o_mem_req.valid && q.op == DSU_OP_LEFT
        |-> o_mem_req.be == (q.big ? (DSU_BE_ALL << q.ea[2:0])
                                   : (DSU_BE_ALL >> (3'h7 - q.ea[2:0]))))
        else $error("store-left byte enables wrong");
    chk_right_lanes: assert property (o_mem_req.valid && q.op == DSU_OP_RIGHT
        |-> o_mem_req.be == (q.big ? (DSU_BE_ALL >> (3'h7 - q.ea[2:0]))
                                   : (DSU_BE_ALL << q.ea[2:0])))
        else $error("store-right byte enables wrong");

    cov_split_store: cover property (q.split && q.st == DSU_ST_WR2 && i_mem_ack);
    cov_cop2_pair: cover property (q.op == DSU_OP_COP2 && q.st == DSU_ST_WR2 && i_mem_ack);
    cov_bus_error: cover property (o_exc && o_exc_code == DSU_EXC_BUS);
    cov_left_done: cover property (o_done && q.op == DSU_OP_LEFT);

endmodule : dsu_store_unit

`default_nettype wire

// *** dsu_far_model.sv ***
/*
 * dsu_far_model: translation unit and write port that face the store unit.
 * assumes one translation per store and at most two write beats per store;
 * faults, delays and the failing beat are chosen by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module dsu_far_model
    import dsu_pkg::*;
#(
    parameter logic [63:0] XMASK = 64'h0000_0f00_0000_0000
)
(
    // clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_nrst,
    // scenario control
    input  wire logic [1:0]    i_delay,
    input  wire logic [3:0]    i_fault,
    input  wire logic [1:0]    i_err_beat,
    // translation
    input  wire logic          i_xlat_req,
    input  wire logic [63:0]   i_xlat_vaddr,
    output logic               o_xlat_ack,
    output dsu_xlat_rsp_t      o_xlat_rsp,
    // memory write
    input  wire dsu_mem_req_t  i_mem_req,
    output logic               o_mem_ack,
    output logic               o_mem_bus_err
);
    logic [1:0]    xcnt_q;
    logic [1:0]    mcnt_q;
    logic [1:0]    beat_q;
    dsu_xlat_rsp_t rsp;

    // page bits remapped, page offset kept, attribute from the page
    assign rsp = '{paddr: i_xlat_vaddr ^ XMASK, cca: i_xlat_vaddr[14:12] ^ 3'h5,
                   refill: i_fault[3], invalid: i_fault[2],
                   modified: i_fault[1], watch: i_fault[0]};

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            xcnt_q        <= 2'h0;
            mcnt_q        <= 2'h0;
            beat_q        <= 2'h0;
            o_xlat_ack    <= 1'b0;
            o_xlat_rsp    <= '0;
            o_mem_ack     <= 1'b0;
            o_mem_bus_err <= 1'b0;
        end
        else
        begin
            // outside an answer the lines show garbage, not the last value
            o_xlat_ack    <= 1'b0;
            o_xlat_rsp    <= ~rsp;
            xcnt_q        <= 2'h0;
            o_mem_ack     <= 1'b0;
            o_mem_bus_err <= ~o_mem_bus_err;
            mcnt_q        <= 2'h0;
            if (i_xlat_req && !o_xlat_ack)
            begin
                xcnt_q <= xcnt_q + 2'h1;
                if (xcnt_q >= i_delay)
                begin
                    o_xlat_ack <= 1'b1;
                    o_xlat_rsp <= rsp;
                end
            end
            if (!i_mem_req.valid)
                beat_q <= 2'h0;
            else if (o_mem_ack)
                beat_q <= beat_q + 2'h1;
            else
            begin
                mcnt_q <= mcnt_q + 2'h1;
                if (mcnt_q >= i_delay)
                begin
                    o_mem_ack     <= 1'b1;
                    o_mem_bus_err <= (beat_q + 2'h1) == i_err_beat;
                end
            end
        end
    end
endmodule : dsu_far_model
`default_nettype wire

// *** dsu_store_unit_bench.sv ***
/*
 * dsu_store_unit_bench: self-checking bench of the doubleword store unit.
 * assumes dsu_far_model on the far side; a reference model here predicts
 * every write beat and every completion code.
 */
`timescale 1ns/1ps
`default_nettype none
module dsu_store_unit_bench
    import dsu_pkg::*;
;
    localparam logic [63:0] XMASK = 64'h0000_0f00_0000_0000;
    logic          clk;
    logic          nrst;
    logic          r6;
    logic          big;
    logic          usable;
    logic          ivalid;
    logic          rsvd;
    dsu_issue_t    iss;
    logic          ready;
    logic          xreq;
    logic [63:0]   xva;
    logic          xack;
    dsu_xlat_rsp_t xrsp;
    dsu_mem_req_t  mreq;
    logic          mack;
    logic          berr;
    logic          done;
    logic          exc;
    dsu_exc_t      code;
    logic [1:0]    dly;
    logic [3:0]    flt;
    logic [1:0]    ebeat;
    logic [31:0]   lfsr_q;
    int            num_errors;
    int            tests_run;

    dsu_store_unit dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_release6(r6), .i_big_endian(big),
        .i_cop_usable(usable), .i_issue_valid(ivalid), .i_issue(iss),
        .i_issue_reserved(rsvd), .o_ready(ready), .o_xlat_req(xreq),
        .o_xlat_vaddr(xva), .i_xlat_ack(xack), .i_xlat_rsp(xrsp), .o_mem_req(mreq),
        .i_mem_ack(mack), .i_mem_bus_err(berr), .o_done(done), .o_exc(exc),
        .o_exc_code(code)
    );

    dsu_far_model #(.XMASK(XMASK)) far (
        .i_core_clk(clk), .i_nrst(nrst), .i_delay(dly), .i_fault(flt),
        .i_err_beat(ebeat), .i_xlat_req(xreq), .i_xlat_vaddr(xva),
        .o_xlat_ack(xack), .o_xlat_rsp(xrsp), .i_mem_req(mreq), .o_mem_ack(mack),
        .o_mem_bus_err(berr)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    function automatic logic [63:0] swap8(input logic [63:0] v);
        for (int i = 0; i < 8; i++)
            swap8[8*i +: 8] = v[8*(7-i) +: 8];
    endfunction : swap8

    function automatic logic [63:0] lanes(input logic [63:0] d, input logic [7:0] be);
        for (int i = 0; i < 8; i++)
            lanes[8*i +: 8] = be[i] ? d[8*i +: 8] : 8'h00;
    endfunction : lanes

    // predicts one store from the issue fields, then issues and watches it
    task automatic store(input logic [3:0] fault, input logic [1:0] eb);
        logic [63:0] ea;
        logic [63:0] pdw;
        logic [63:0] v;
        logic [63:0] x;
        logic [63:0] e_dat [2];
        logic [7:0]  e_be [2];
        logic [63:0] e_adr [2];
        logic [2:0]  k;
        logic        up;
        int          n;
        int          seen;
        logic        fin;
        dsu_exc_t    e_code;
        if (iss.op == DSU_OP_COP2 && r6)
            ea = iss.base + {{53{iss.offset[10]}}, iss.offset[10:0]};
        else
            ea = iss.base + {{48{iss.offset[15]}}, iss.offset};
        k = ea[2:0];
        pdw = (ea ^ XMASK) & DSU_DW_MASK;
        v = (iss.op == DSU_OP_FLT) ? iss.flt_data : iss.int_data;
        if (iss.op == DSU_OP_COP2)
            v = (k == 3'h0) ? {iss.cop2_hi[31:0], iss.cop2_lo[31:0]} : iss.cop2_lo;
        x = big ? swap8(v) : v;
        up = (iss.op == DSU_OP_LEFT) == big;
        n = 1;
        e_code = DSU_EXC_NONE;
        e_adr = '{pdw, pdw + DSU_DW_STEP};
        e_be = '{DSU_BE_ALL, DSU_BE_ALL};
        e_dat = '{x, x};
        if (rsvd || (r6 && iss.op >= DSU_OP_LEFT))
            e_code = DSU_EXC_RESERVED;
        else if ((iss.op == DSU_OP_FLT || iss.op == DSU_OP_COP2) && !usable)
            e_code = DSU_EXC_COP_UNUS;
        else if (!r6 && iss.op <= DSU_OP_COP2 && k != 3'h0)
            e_code = DSU_EXC_ADDR;
        else if (fault != 4'h0)
            e_code = fault[3] ? DSU_EXC_REFILL : fault[2] ? DSU_EXC_INVALID
                   : fault[1] ? DSU_EXC_MODIFIED : DSU_EXC_WATCH;
        else if (iss.op >= DSU_OP_LEFT)
        begin
            e_be[0] = up ? DSU_BE_ALL << k : DSU_BE_ALL >> (3'h7 - k);
            e_dat[0] = up ? x << (8 * k) : x >> (8 * (3'h7 - k));
        end
        else if (iss.op == DSU_OP_COP2 && k == 3'h0)
        begin
            n = 2;
            if (big)
            begin
                e_be = '{DSU_BE_HI_WORD, DSU_BE_LO_WORD};
                e_adr = '{pdw | DSU_WORD_FLIP, pdw};
            end
            else
            begin
                e_be = '{DSU_BE_LO_WORD, DSU_BE_HI_WORD};
                e_adr = '{pdw, pdw | DSU_WORD_FLIP};
            end
        end
        else if (k != 3'h0)
        begin
            n = 2;
            e_be = '{DSU_BE_ALL << k, DSU_BE_ALL >> (4'h8 - k)};
            e_dat = '{x << (8 * k), x >> (64 - 8 * k)};
        end
        if (e_code == DSU_EXC_NONE && eb != 2'h0 && eb <= n)
        begin
            n = eb;
            e_code = DSU_EXC_BUS;
        end
        else if (e_code != DSU_EXC_NONE)
            n = 0;
        flt = fault;
        ebeat = eb;
        chk("ready", ready, 1'b1);
        ivalid = 1'b1;
        @(negedge clk);
        ivalid = 1'b0;
        seen = 0;
        fin = 1'b0;
        for (int j = 0; j < 100 && !fin; j++)
        begin
            if (xreq === 1'b1 && xack === 1'b1)
                chk("vaddr", xva, ea);
            if (mreq.valid === 1'b1 && mack === 1'b1)
            begin
                chk("addr", mreq.addr, e_adr[seen % 2]);
                chk("be", mreq.be, e_be[seen % 2]);
                chk("data", lanes(mreq.data, mreq.be), lanes(e_dat[seen % 2], e_be[seen % 2]));
                chk("cca", mreq.cca, ea[14:12] ^ 3'h5);
                seen++;
            end
            if (done === 1'b1 || exc === 1'b1)
            begin
                fin = 1'b1;
                chk("done", done, e_code == DSU_EXC_NONE);
                chk("code", code, e_code);
                chk("beats", seen, n);
            end
            else
                @(negedge clk);
        end
        if (!fin)
        begin
            num_errors++;
            final_report();
        end
    endtask : store

    task automatic rand_store();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        a = rnd();
        b = rnd();
        c = rnd();
        iss.op = dsu_op_t'(a[2:0] % 3'h5);
        iss.base = {b, c};
        iss.offset = a[31:16];
        if (a[3])
            iss.base[2:0] = 3'h0;
        if (a[3])
            iss.offset[2:0] = 3'h0;
        b = rnd();
        c = rnd();
        iss.int_data = {b, c};
        iss.flt_data = {c, b};
        iss.cop2_lo = {b ^ a, c};
        iss.cop2_hi = {c ^ a, b};
        r6 = a[4];
        big = a[5];
        usable = a[8:6] != 3'h0;
        rsvd = a[12:9] == 4'h0;
        dly = a[14:13];
        store((a[15] & b[0]) ? b[4:1] : 4'h0, (b[7:6] == 2'h3) ? {1'b0, b[8]} + 2'h1 : 2'h0);
    endtask : rand_store

    initial
    begin
        nrst = 1'b0;
        {r6, big, usable, ivalid, rsvd} = 5'h04;
        iss = '0;
        dly = 2'h0;
        flt = 4'h0;
        ebeat = 2'h0;
        lfsr_q = 32'h6a71;
        num_errors = 0;
        tests_run = 0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 800; i++)
            rand_store();
        $display("test random stores done");
        iss.op = DSU_OP_INT;
        iss.base = 64'h0000_1234_5678_9a00;
        iss.offset = 16'hfff8;
        {r6, rsvd, usable} = 3'h1;
        for (int m = 1; m < 16; m++)
            store(m[3:0], 2'h0);
        $display("test translation faults done");
        r6 = 1'b1;
        iss.offset = 16'h0003;
        for (int m = 1; m < 3; m++)
            store(4'h0, m[1:0]);
        $display("test bus errors done");
        r6 = 1'b0;
        iss.op = DSU_OP_LEFT;
        iss.offset = 16'h0002;
        store(4'h0, 2'h0);
        iss.op = DSU_OP_RIGHT;
        iss.offset = 16'h0009;
        store(4'h0, 2'h0);
        $display("test paired partial stores done");
        final_report();
    end
endmodule : dsu_store_unit_bench
`default_nettype wire
